// *** rtl/eec_pkg.sv ***
package eec_pkg;

    // Width of each error event counter.
    localparam int          CNT_W        = 16;
    // Width of the processor data bus.
    localparam int          BYTE_W       = 8;
    // Width of the processor address bus.
    localparam int          ADDR_W       = 8;
    // Number of counters in the bank.
    localparam int          NUM_CNT      = 3;

    // Line code violation count, high and low byte.
    localparam logic [7:0]  LINE_CODE_VIOLATION_HIGH_ADDR = 8'h50;
    localparam logic [7:0]  LINE_CODE_VIOLATION_LOW_ADDR  = 8'h51;
    // Framing bit or byte error count, high and low byte.
    localparam logic [7:0]  FRM_HIGH_ADDR = 8'h52;
    localparam logic [7:0]  FRM_LOW_ADDR  = 8'h53;
    // Parity error count, high and low byte.
    localparam logic [7:0]  PAR_HIGH_ADDR = 8'h54;
    localparam logic [7:0]  PAR_LOW_ADDR  = 8'h55;
    // Shared holding register for the unread byte.
    localparam logic [7:0]  HOLD_ADDR     = 8'h6c;

    // Reset values of the counters and the holding register.
    localparam logic [15:0] CNT_RESET     = 16'h0000;
    localparam logic [7:0]  HOLD_RESET    = 8'h00;
    // Value returned for an unmapped address.
    localparam logic [7:0]  UNMAPPED_DATA = 8'h00;

endpackage : eec_pkg

// *** rtl/eec_cnt_if.sv ***
`timescale 1ns/10ps
// Connects one counter to the read and event logic of the bank.
interface eec_cnt_if #(
    parameter int CNT_W = 16
);
    // One-cycle pulse for each counted event.
    logic             evt;
    // One-cycle pulse that restarts the count from zero.
    logic             clr;
    // Present count, straight from the counter's flip-flops.
    logic [CNT_W-1:0] count;

    // The counter itself.
    modport cnt (input evt, input clr, output count);
    // The bank logic that feeds and reads it.
    modport ctl (output evt, output clr, input count);
endinterface : eec_cnt_if

// *** rtl/eec_counter.sv ***
`timescale 1ns/10ps
// One saturating clear-on-read event counter.
module eec_counter #(
    parameter int CNT_W = 16
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Event, clear and count.
    eec_cnt_if.cnt    port_if
);

    // Largest count that the counter holds.
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    // Count register.
    logic [CNT_W-1:0] count_reg;

    // Counts events; a clear restarts the count, keeping a same-cycle event.
    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= CNT_W'(eec_pkg::CNT_RESET);
        end else if (port_if.clr) begin
            count_reg <= {{(CNT_W-1){1'b0}}, port_if.evt};
        end else if (port_if.evt && count_reg != CNT_MAX) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // The count leaves the module straight from its register.
    assign port_if.count = count_reg;

    // A clear leaves only a same-cycle event in the count.
    property p_clear;
        @(posedge clk) disable iff (rst)
        port_if.clr |=> count_reg == {{(CNT_W-1){1'b0}}, $past(port_if.evt)};
    endproperty
    a_clear: assert property (p_clear)
        else $error("counter not restarted by clearing read");

    // An event below the maximum adds exactly one.
    property p_inc;
        @(posedge clk) disable iff (rst)
        (!port_if.clr && port_if.evt && count_reg != CNT_MAX)
            |=> count_reg == $past(count_reg) + 1'b1;
    endproperty
    a_inc: assert property (p_inc)
        else $error("counter missed an event");

    // At the maximum the count stays there until cleared.
    property p_sat;
        @(posedge clk) disable iff (rst)
        (!port_if.clr && count_reg == CNT_MAX) |=> count_reg == CNT_MAX;
    endproperty
    a_sat: assert property (p_sat)
        else $error("counter wrapped instead of saturating");

    // Without event or clear the count does not move.
    property p_idle;
        @(posedge clk) disable iff (rst)
        (!port_if.clr && !port_if.evt) |=> $stable(count_reg);
    endproperty
    a_idle: assert property (p_idle)
        else $error("counter moved without an event");

endmodule : eec_counter

// *** rtl/eec_bank.sv ***
`timescale 1ns/10ps
// Function
// - Count line code violations, bytes 0x50/0x51
// - Count framing errors, bytes 0x52/0x53
// - Count parity errors, bytes 0x54/0x55
// - Lower address high byte, next low
// - Reading a counter restarts it at zero
// - All counter bytes read zero after reset
// - Whole counter clears on first byte read
// - Unread byte copied to holding register 0x6C
module eec_bank #(
    parameter int CNT_W = eec_pkg::CNT_W
) (
    // Clock and synchronous reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Processor read port, same clock domain.
    input  wire logic [7:0]  addr,
    input  wire logic        rd_en,
    output logic      [7:0]  rd_data,
    output logic             rd_valid,
    // Event pulses from the receive framer, same clock domain.
    input  wire logic        line_code_violation_event,
    input  wire logic        framing_error_event,
    input  wire logic        parity_error_event
);

    // True when the address names a byte of one of the counters.
    function automatic logic is_counter(input logic [7:0] a);
        return (a >= eec_pkg::LINE_CODE_VIOLATION_HIGH_ADDR) &&
               (a <= eec_pkg::PAR_LOW_ADDR);
    endfunction : is_counter

    // Index of the counter that a counter address names.
    function automatic logic [1:0] cnt_index(input logic [7:0] a);
        logic [7:0] off;
        off = a - eec_pkg::LINE_CODE_VIOLATION_HIGH_ADDR;
        return off[2:1];
    endfunction : cnt_index

    // Links to the three counters.
    eec_cnt_if #(.CNT_W(CNT_W)) cnt_if [eec_pkg::NUM_CNT] ();
    // Counts gathered into an array the read mux can index.
    logic [CNT_W-1:0] cnt_val [eec_pkg::NUM_CNT];
    // Count of the counter that the present address selects.
    logic [CNT_W-1:0] sel_cnt;
    // A read of any counter byte in this cycle.
    logic             cnt_read;
    // Byte returned and byte saved for the present read.
    logic [7:0]       rd_data_next;
    logic [7:0]       hold_next;
    // Holding register for the unread byte.
    logic [7:0]       hold_reg;
    // Read data and valid registers.
    logic [7:0]       rd_data_reg;
    logic             rd_valid_reg;

    // Framer events enter their counters without synchronisers.
    // line code violations
    assign cnt_if[0].evt = line_code_violation_event;
    assign cnt_if[1].evt = framing_error_event;
    assign cnt_if[2].evt = parity_error_event;

    assign cnt_read = rd_en && is_counter(addr);

    // One counter per link; each is cleared by a read of either byte.
    for (genvar g = 0; g < eec_pkg::NUM_CNT; g++) begin : g_cnt
        assign cnt_if[g].clr = cnt_read && (cnt_index(addr) == 2'(g));
        assign cnt_val[g]    = cnt_if[g].count;
        eec_counter #(.CNT_W(CNT_W)) u_counter (
            .clk     (clk),
            .rst     (rst),
            .port_if (cnt_if[g])
        );
    end

    // Selects the requested byte and the partner byte to be held.
    always_comb begin
        sel_cnt      = cnt_val[0];
        rd_data_next = eec_pkg::UNMAPPED_DATA;
        hold_next    = hold_reg;
        if (is_counter(addr)) begin
            // Index 3 cannot occur inside the counter range.
            sel_cnt = cnt_val[cnt_index(addr)];
            if (addr[0]) begin
                rd_data_next = sel_cnt[7:0];
                hold_next    = sel_cnt[15:8];
            end else begin
                rd_data_next = sel_cnt[15:8];
                hold_next    = sel_cnt[7:0];
            end
        end else if (addr == eec_pkg::HOLD_ADDR) begin
            // The holding register reads out and then clears.
            rd_data_next = hold_reg;
            hold_next    = eec_pkg::HOLD_RESET;
        end
    end

    // Holding register: loaded by a counter read, cleared by its own read.
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_reg <= eec_pkg::HOLD_RESET;
        end else if (rd_en) begin
            hold_reg <= hold_next;
        end
    end

    // Read data register: changes only on a read.
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data_reg <= eec_pkg::UNMAPPED_DATA;
        end else if (rd_en) begin
            rd_data_reg <= rd_data_next;
        end
    end

    // Read valid: one cycle after each read strobe.
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_en;
        end
    end

    assign rd_data  = rd_data_reg;
    assign rd_valid = rd_valid_reg;

    // Copy of the selected count, read only by the checks below.
    logic [CNT_W-1:0] chk_sel_q;
    always_ff @(posedge clk) begin
        chk_sel_q <= sel_cnt;
    end

    // A high-byte read returns the high byte and holds the low byte.
    property p_read_high;
        @(posedge clk) disable iff (rst)
        (cnt_read && !addr[0]) |=>
            (rd_data == chk_sel_q[15:8]) && (hold_reg == chk_sel_q[7:0]);
    endproperty
    a_read_high: assert property (p_read_high)
        else $error("high byte read returned the wrong bytes");

    // A low-byte read returns the low byte and holds the high byte.
    property p_read_low;
        @(posedge clk) disable iff (rst)
        (cnt_read && addr[0]) |=>
            (rd_data == chk_sel_q[7:0]) && (hold_reg == chk_sel_q[15:8]);
    endproperty
    a_read_low: assert property (p_read_low)
        else $error("low byte read returned the wrong bytes");

    // The whole line code violation counter clears at the first byte read.
    property p_first_clears;
        @(posedge clk) disable iff (rst)
        (cnt_read && cnt_index(addr) == 2'd0 && !line_code_violation_event)
            |=> cnt_val[0] == eec_pkg::CNT_RESET;
    endproperty
    a_first_clears: assert property (p_first_clears)
        else $error("counter not cleared by first byte read");

    // The holding register reads back and then clears.
    property p_hold_read;
        @(posedge clk) disable iff (rst)
        (rd_en && addr == eec_pkg::HOLD_ADDR) |=>
            (rd_data == $past(hold_reg)) && (hold_reg == eec_pkg::HOLD_RESET);
    endproperty
    a_hold_read: assert property (p_hold_read)
        else $error("holding register read misbehaved");

    // An unmapped read returns zero with valid one cycle later.
    property p_unmapped;
        @(posedge clk) disable iff (rst)
        (rd_en && !is_counter(addr) && addr != eec_pkg::HOLD_ADDR) |=>
            rd_valid && rd_data == eec_pkg::UNMAPPED_DATA;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read did not return zero");

    // After reset the read port, the holding register and the parity count read zero.
    property p_reset_zero;
        @(posedge clk)
        rst |=> (rd_data == eec_pkg::UNMAPPED_DATA) && !rd_valid &&
                (hold_reg == eec_pkg::HOLD_RESET) &&
                (cnt_val[2] == eec_pkg::CNT_RESET);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("state not zero after reset");

    // A framing counter read clears the whole count at once.
    property p_frm_clears;
        @(posedge clk) disable iff (rst)
        (cnt_read && cnt_index(addr) == 2'd1 && !framing_error_event)
            |=> cnt_val[1] == eec_pkg::CNT_RESET;
    endproperty
    a_frm_clears: assert property (p_frm_clears)
        else $error("framing counter not cleared by its read");

    // A parity counter read restarts that count from zero.
    property p_par_clears;
        @(posedge clk) disable iff (rst)
        (cnt_read && cnt_index(addr) == 2'd2 && !parity_error_event)
            |=> cnt_val[2] == eec_pkg::CNT_RESET;
    endproperty
    a_par_clears: assert property (p_par_clears)
        else $error("parity counter not cleared by its read");

    // Without a read the data output holds and valid stays low.
    property p_read_quiet;
        @(posedge clk) disable iff (rst)
        !rd_en |=> $stable(rd_data) && !rd_valid;
    endproperty
    a_read_quiet: assert property (p_read_quiet)
        else $error("read port moved without a read strobe");

endmodule : eec_bank

// *** verification/eec_framer_model.sv ***
`timescale 1ns/10ps
// Stands in for the receive framer: raises event pulses on request.
module eec_framer_model (
    // Clock.
    input  wire logic clk,
    // Event pulses towards the bank.
    output logic      line_code_violation_event,
    output logic      framing_error_event,
    output logic      parity_error_event
);
    // One detector line per counter, indexed by counter number.
    logic [2:0] evt_reg;

    // Each detector drives its own event pin.
    assign line_code_violation_event = evt_reg[0];
    assign framing_error_event       = evt_reg[1];
    assign parity_error_event        = evt_reg[2];

    // All detectors are quiet at time zero.
    initial begin
        evt_reg = 3'h0;
    end

    // Holds one detector high for n cycles, one error per high cycle.
    // one pulse each
    task automatic pulse(input int chan, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1 evt_reg[chan] = 1'b1;
        end
        @(posedge clk);
        #1 evt_reg[chan] = 1'b0;
    endtask : pulse
endmodule : eec_framer_model

// *** verification/eec_bank_bench.sv ***
`timescale 1ns/10ps
// Reads the counter bank while the framer model feeds it events.
module eec_bank_bench;
    // Clock, reset and read port.
    logic       clk;
    logic       rst;
    logic [7:0] addr;
    logic       rd_en;
    logic [7:0] rd_data;
    logic       rd_valid;
    // Event lines from the framer model.
    logic       line_code_violation_event;
    logic       framing_error_event;
    logic       parity_error_event;
    // Mismatch and comparison counters.
    int         n_fail;
    int         n_checks;

    // Device under test.
    eec_bank #(.CNT_W(eec_pkg::CNT_W)) u_eec_bank (
        .clk                       (clk),
        .rst                       (rst),
        .addr                      (addr),
        .rd_en                     (rd_en),
        .rd_data                   (rd_data),
        .rd_valid                  (rd_valid),
        .line_code_violation_event (line_code_violation_event),
        .framing_error_event       (framing_error_event),
        .parity_error_event        (parity_error_event)
    );

    // Event source.
    eec_framer_model u_eec_framer_model (
        .clk                       (clk),
        .line_code_violation_event (line_code_violation_event),
        .framing_error_event       (framing_error_event),
        .parity_error_event        (parity_error_event)
    );

    // A 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Compares one byte and reports a mismatch at once.
    task automatic check(input logic [7:0] seen, input logic [7:0] expd);
        n_checks++;
        if (seen !== expd) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask : check

    // One read: strobe for one edge, then look at the answer it raised.
    task automatic rd(input logic [7:0] a, input logic [7:0] expd);
        @(posedge clk);
        #1 rd_en = 1'b1;
        addr = a;
        check({7'h00, rd_valid}, 8'h00);
        @(posedge clk);
        #1 rd_en = 1'b0;
        check({7'h00, rd_valid}, 8'h01);
        check(rd_data, expd);
    endtask : rd

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    // Cuts a hang short well after the longest expected run.
    initial begin
        #1800000;
        n_fail++;
        $display("Watchdog expired at %0t", $time);
        summarize();
    end

    // Main test sequence.
    initial begin
        logic [7:0]  hi;
        logic [15:0] n;
        rst = 1'b1;
        rd_en = 1'b0;
        addr = 8'h00;
        n_fail = 0;
        n_checks = 0;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        // Every counter byte and the holding byte start at zero.
        for (int a = 0; a < 6; a++) begin
            rd(eec_pkg::LINE_CODE_VIOLATION_HIGH_ADDR + 8'(a), 8'h00);
        end
        rd(eec_pkg::HOLD_ADDR, eec_pkg::HOLD_RESET);
        $display("Test reset values done");
        // Each counter in turn: high byte first, then low byte first.
        for (int i = 0; i < 3; i++) begin
            hi = eec_pkg::LINE_CODE_VIOLATION_HIGH_ADDR + 8'(2 * i);
            n = 16'h0103 + 16'(i * 16'h0111);
            u_eec_framer_model.pulse(i, int'(n));
            rd(8'h40, eec_pkg::UNMAPPED_DATA);
            rd(hi, n[15:8]);
            rd(eec_pkg::HOLD_ADDR, n[7:0]);
            rd(eec_pkg::HOLD_ADDR, 8'h00);
            rd(hi, 8'h00);
            u_eec_framer_model.pulse(i, 5);
            rd(hi + 8'h01, 8'h05);
            rd(hi, 8'h00);
            rd(eec_pkg::HOLD_ADDR, 8'h00);
            // An event lands on the same edge as the clearing read.
            fork
                rd(hi + 8'h01, 8'h00);
                u_eec_framer_model.pulse(i, 1);
            join
            rd(hi + 8'h01, 8'h01);
            $display("Test counter %0d done", i);
        end
        // Two events beyond full scale must leave the count pinned.
        u_eec_framer_model.pulse(2, 65537);
        rd(eec_pkg::PAR_HIGH_ADDR, 8'hff);
        rd(eec_pkg::HOLD_ADDR, 8'hff);
        $display("Test saturation done");
        summarize();
    end
endmodule : eec_bank_bench
